//--- logic/sbps_pkg.sv
// Purpose: Shared constants and types for the standby power sequencer
// Assumes: 100 MHz core clock
// Notes:   Times are kept in their own units; cycle counts derive from them
package sbps_pkg;
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned DEBOUNCE_US    = 1_000;
	localparam int unsigned PRESS_MS       = 50;
	localparam int unsigned READY_MS       = 300;
	localparam int unsigned AUTOWAKE_S     = 120;
	localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
	localparam int unsigned PRESS_CYC      = (CLK_HZ / 1_000) * PRESS_MS;
	localparam int unsigned READY_CYC      = (CLK_HZ / 1_000) * READY_MS;
	localparam longint unsigned AUTOWAKE_CYC = longint'(CLK_HZ) * AUTOWAKE_S;
	localparam int unsigned CNT_W          = 40;

	// Power states: off is reset, boot is active but not yet ready
	typedef enum logic [2:0] {
		ST_BOOT     = 3'b000,
		ST_ACTIVE   = 3'b001,
		ST_STOPPROC = 3'b010,
		ST_UNMOUNT  = 3'b011,
		ST_STANDBY  = 3'b100
	} sbps_state_t;

	// Handshake with the software shutdown agent
	typedef struct packed {
		logic stop_proc_req;
		logic unmount_req;
		logic load_boot_cfg;
	} sbps_sw_req_t;

	typedef struct packed {
		logic stop_proc_done;
		logic unmount_done;
	} sbps_sw_ack_t;
endpackage : sbps_pkg

//--- logic/sbps_press_qual.sv
// Purpose: Debounce the toggle input and qualify long-enough presses
// Assumes: Pin is asynchronous, idles high through a pull-up
// Notes:   One pulse per press, emitted once the low time is reached
`timescale 1ns/10ps
module sbps_press_qual
	import sbps_pkg::*;
#(
	parameter int unsigned DEB_CYC   = DEBOUNCE_CYC,
	parameter int unsigned PRESS_LEN = PRESS_CYC
) (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	// Pin and result
	input  wire logic power_toggle_input_i,
	output logic      press_o
);
	logic        sync1;
	logic        sync2;
	logic        deb;
	logic [31:0] deb_cnt;
	logic [31:0] low_cnt;
	logic        fired;

	// Two-stage synchroniser; the pin idles high like the pull-up
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
		end else begin
			sync1 <= power_toggle_input_i;
			sync2 <= sync1;
		end
	end

	// Debouncer: the level must stay steady before it is accepted
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			deb     <= 1'b1;
			deb_cnt <= 32'h0000_0000;
		end else if (sync2 == deb) begin
			deb_cnt <= 32'h0000_0000;
		end else if (deb_cnt >= DEB_CYC - 1) begin
			deb     <= sync2;
			deb_cnt <= 32'h0000_0000;
		end else begin
			deb_cnt <= deb_cnt + 32'h0000_0001;
		end
	end

	// Low-duration qualifier; re-arms only once the input returns high
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			low_cnt <= 32'h0000_0000;
			fired   <= 1'b0;
			press_o <= 1'b0;
		end else begin
			press_o <= 1'b0;
			if (deb) begin
				low_cnt <= 32'h0000_0000;
				fired   <= 1'b0;
			end else if (!fired) begin
				if (low_cnt >= PRESS_LEN - 1) begin
					press_o <= 1'b1;
					fired   <= 1'b1;
				end else begin
					low_cnt <= low_cnt + 32'h0000_0001;
				end
			end
		end
	end
endmodule : sbps_press_qual

//--- logic/sbps_top.sv
// Purpose: Active/standby sequencing with orderly shutdown and supply control
// Assumes: Runs from the always-on supply and clock; reset is power-on
// Notes:   Shutdown steps are handed to software through a request/done pair
`timescale 1ns/10ps

// Functional notes
// - Toggle state when the toggle input stays low at least 50 ms.
// - Toggle input idles high and is debounced before qualification.
// - Ready indicator high only when active; low in standby and reset.
// - Ready rises about 300 ms after power-up, reset or wake.
// - Standby requested by host command or qualified press.
// - Stop processes, then unmount card, then drop the supply request.
// - A qualified press in standby wakes and raises the supply request.
// - After wake, restart from the stored boot configuration.
// - Without a power switch, skip power-off and wake after 2 minutes.
// - Only off, active, standby; standby only via orderly shutdown.
module sbps_top
	import sbps_pkg::*;
#(
	parameter int unsigned      DEB_CYC   = DEBOUNCE_CYC,
	parameter int unsigned      PRESS_LEN = PRESS_CYC,
	parameter int unsigned      READY_LEN = READY_CYC,
	parameter longint unsigned  WAKE_LEN  = AUTOWAKE_CYC
) (
	// Clock and reset
	input  wire logic   core_clk_i,
	input  wire logic   sys_rst_i,
	// Pins
	input  wire logic   power_toggle_input_i,
	input  wire logic   switch_fitted_i,
	output logic        supply_switch_request_o,
	output logic        module_ready_o,
	// Host command and software agent
	input  wire logic   power_mode_command_standby_i,
	input  sbps_sw_ack_t sw_ack_i,
	output sbps_sw_req_t sw_req_o,
	output sbps_state_t state_o
);
	sbps_state_t             state;
	sbps_state_t             next_state;
	logic                    press;
	logic                    fitted;
	logic [CNT_W-1:0]        timer;
	logic                    timer_done;

	sbps_press_qual #(
		.DEB_CYC   (DEB_CYC),
		.PRESS_LEN (PRESS_LEN)
	) u_qual (
		.core_clk_i           (core_clk_i),
		.sys_rst_i            (sys_rst_i),
		.power_toggle_input_i (power_toggle_input_i),
		.press_o              (press)
	);

	// Strap of the switch option, caught while held in reset
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			fitted <= switch_fitted_i;
		end
	end

	// Shared timer: ready delay in boot, auto-wake in standby without a switch fitted, where the supply stays on
	always_comb begin
		timer_done = 1'b0;
		if (state == ST_BOOT) begin
			timer_done = (timer >= CNT_W'(READY_LEN - 1));
		end else if (state == ST_STANDBY) begin
			timer_done = (timer >= CNT_W'(WAKE_LEN - 1));
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || next_state != state) begin
			timer <= '0;
		end else if (!timer_done) begin
			timer <= timer + CNT_W'(1);
		end
	end

	// Next-state logic; a press during shutdown is consumed and ignored
	always_comb begin
		next_state = state;
		unique case (state)
			ST_BOOT: begin
				if (timer_done) begin
					next_state = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (press || power_mode_command_standby_i) begin
					next_state = ST_STOPPROC;
				end
			end
			ST_STOPPROC: begin
				if (sw_ack_i.stop_proc_done) begin
					next_state = ST_UNMOUNT;
				end
			end
			ST_UNMOUNT: begin
				if (sw_ack_i.unmount_done) begin
					next_state = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (press || (!fitted && timer_done)) begin
					next_state = ST_BOOT;
				end
			end
			default: begin
				next_state = ST_BOOT;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state <= ST_BOOT;
		end else begin
			state <= next_state;
		end
	end

	// Registered outputs; the supply stays on without a switch fitted
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			supply_switch_request_o <= 1'b1;
			module_ready_o          <= 1'b0;
			sw_req_o                <= '0;
			state_o                 <= ST_BOOT;
		end else begin
			supply_switch_request_o <= (next_state != ST_STANDBY) || !fitted;
			module_ready_o          <= (next_state == ST_ACTIVE);
			sw_req_o.stop_proc_req  <= (next_state == ST_STOPPROC);
			sw_req_o.unmount_req    <= (next_state == ST_UNMOUNT);
			sw_req_o.load_boot_cfg  <= (next_state == ST_BOOT);
			state_o                 <= next_state;
		end
	end
endmodule : sbps_top

//--- tb/sbps_top_checker.sv
// Purpose: Port-level checks for the power sequencer
// Assumes: Strap changes only during reset
// Notes:   Boot length follows the ready parameter of the bound design
`timescale 1ns/10ps
module sbps_top_checker
	import sbps_pkg::*;
#(
	parameter int unsigned READY_LEN = READY_CYC
) (
	// Watched ports
	input wire logic   core_clk_i,
	input wire logic   sys_rst_i,
	input wire logic   switch_fitted_i,
	input wire logic   power_mode_command_standby_i,
	input wire logic   supply_switch_request_o,
	input wire logic   module_ready_o,
	input sbps_sw_ack_t sw_ack_i,
	input sbps_sw_req_t sw_req_o,
	input sbps_state_t  state_o
);
	logic [31:0] boot_len;

	// Cycles spent in boot since release or wake; a short boot would slip past a fixed depth
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || state_o != ST_BOOT) begin
			boot_len <= 32'h0000_0000;
		end else begin
			boot_len <= boot_len + 32'h0000_0001;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_ready_only_active: assert property (module_ready_o |-> state_o == ST_ACTIVE)
		else $error("ready outside active");
	a_stop_waits: assert property (state_o == ST_STOPPROC && !sw_ack_i.stop_proc_done
		|=> state_o == ST_STOPPROC) else $error("left stop early");
	a_unmount_next: assert property (state_o == ST_STOPPROC && sw_ack_i.stop_proc_done
		|=> state_o == ST_UNMOUNT) else $error("no unmount");
	a_cmd_standby: assert property (state_o == ST_ACTIVE && power_mode_command_standby_i
		|=> state_o == ST_STOPPROC) else $error("command lost");
	a_wake_boot: assert property ($rose(supply_switch_request_o)
		|-> state_o == ST_BOOT && sw_req_o.load_boot_cfg) else $error("bad wake");
	a_ready_delay: assert property ($rose(module_ready_o) |-> boot_len == READY_LEN)
		else $error("ready delay wrong");
	a_standby_entry: assert property ($rose(state_o == ST_STANDBY)
		|-> $past(state_o) == ST_UNMOUNT) else $error("bad standby entry");
	a_unfit_supply: assert property (state_o == ST_STANDBY && !switch_fitted_i
		|-> supply_switch_request_o) else $error("supply cut unfitted");
	a_req_track: assert property (sw_req_o.stop_proc_req == (state_o == ST_STOPPROC)
		&& sw_req_o.unmount_req == (state_o == ST_UNMOUNT)) else $error("step request off");
endmodule : sbps_top_checker
bind sbps_top sbps_top_checker #(.READY_LEN(READY_LEN)) u_chk (
	.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
	.switch_fitted_i(switch_fitted_i), .supply_switch_request_o(supply_switch_request_o),
	.power_mode_command_standby_i(power_mode_command_standby_i), .sw_ack_i(sw_ack_i),
	.module_ready_o(module_ready_o), .sw_req_o(sw_req_o), .state_o(state_o));

//--- tb/sbps_partner.sv
// Purpose: Power switch, button and software agent stand-in
// Assumes: Latency set by the bench
// Notes:   Done flags drop with their request
`timescale 1ns/10ps
module sbps_partner
	import sbps_pkg::*;
(
	// Clock and controls
	input wire logic   core_clk_i,
	input wire logic   press_i,
	input wire logic   [3:0] lat_i,
	input wire logic   supply_i,
	input sbps_sw_req_t req_i,
	// Answers
	output sbps_sw_ack_t ack_o,
	output logic       main_on_o,
	output logic       pin_o
);
	logic [3:0] cnt;
	// Busy time per shutdown step
	always_ff @(posedge core_clk_i) begin
		cnt <= ((req_i.stop_proc_req | req_i.unmount_req) && cnt != lat_i) ? cnt + 4'h1 : 4'h0;
	end
	assign ack_o.stop_proc_done = req_i.stop_proc_req && cnt == lat_i;
	assign ack_o.unmount_done = req_i.unmount_req && cnt == lat_i;
	assign main_on_o = supply_i;
	assign pin_o = press_i ? 1'b0 : 1'b1;
endmodule : sbps_partner

//--- tb/tb_standby_power_sequencer.sv
// Purpose: Scenario bench for the power sequencer
// Assumes: Shortened counts
// Notes:   Inputs move at the falling edge
`timescale 1ns/10ps
module tb_standby_power_sequencer;
	import sbps_pkg::*;
	logic clk = 0, rst = 1, btn = 0, fit = 1, cmd = 0;
	logic [3:0] lat = 4'h3;
	logic pin, sup, rdy, mon;
	sbps_sw_ack_t ack;
	sbps_sw_req_t req;
	sbps_state_t st;
	int bad_count = 0, num_checks = 0;
	sbps_top #(.DEB_CYC(4), .PRESS_LEN(20), .READY_LEN(50), .WAKE_LEN(200)) DUT (
		.core_clk_i(clk), .sys_rst_i(rst), .power_toggle_input_i(pin),
		.switch_fitted_i(fit), .supply_switch_request_o(sup), .module_ready_o(rdy),
		.power_mode_command_standby_i(cmd), .sw_ack_i(ack), .sw_req_o(req), .state_o(st));
	sbps_partner u_prt (.core_clk_i(clk), .press_i(btn), .lat_i(lat), .supply_i(sup),
		.req_i(req), .ack_o(ack), .main_on_o(mon), .pin_o(pin));
	initial forever #5 clk = ~clk;
	task chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task wait_st(input sbps_state_t s);
		for (int i = 0; i < 400 && st !== s; i++) @(negedge clk);
		chk(st, s);
	endtask : wait_st
	task press(input int n);
		btn = 1;
		tick(n);
		btn = 0;
		tick(8);
	endtask : press
	task do_reset(input logic f);
		fit = f;
		rst = 1;
		tick(2);
		chk(rdy, 0);
		rst = 0;
	endtask : do_reset
	task pulse_cmd;
		cmd = 1;
		tick(1);
		cmd = 0;
	endtask : pulse_cmd
	// Boot delay before ready
	task t_boot;
		chk(rdy, 0);
		tick(1);
		chk(req.load_boot_cfg, 1);
		tick(40);
		chk(rdy, 0);
		wait_st(ST_ACTIVE);
		chk(rdy, 1);
	endtask : t_boot
	// Host command shutdown, slow agent
	task t_cmd;
		pulse_cmd;
		chk(st, ST_STOPPROC);
		chk(req.stop_proc_req, 1);
		wait_st(ST_UNMOUNT);
		chk(req.unmount_req, 1);
		chk(req.stop_proc_req, 0);
		wait_st(ST_STANDBY);
		chk(sup, 0);
		chk(mon, 0);
		chk(rdy, 0);
	endtask : t_cmd
	// Short press ignored, long press wakes once
	task t_wake;
		press(10);
		chk(st, ST_STANDBY);
		press(40);
		chk(st, ST_BOOT);
		chk(sup, 1);
		chk(mon, 1);
		chk(req.load_boot_cfg, 1);
		wait_st(ST_ACTIVE);
	endtask : t_wake
	// Press shutdown, command in standby refused
	task t_press;
		lat = 4'h0;
		press(40);
		wait_st(ST_STANDBY);
		pulse_cmd;
		tick(3);
		chk(st, ST_STANDBY);
		press(40);
		wait_st(ST_ACTIVE);
	endtask : t_press
	// No switch fitted: supply kept, auto wake
	task t_unfit;
		wait_st(ST_ACTIVE);
		pulse_cmd;
		wait_st(ST_STANDBY);
		chk(sup, 1);
		tick(150);
		chk(st, ST_STANDBY);
		wait_st(ST_BOOT);
	endtask : t_unfit
	task summarize;
		$display("Checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	// Main sequence
	initial begin
		do_reset(1);
		t_boot;
		t_cmd;
		t_wake;
		t_press;
		do_reset(0);
		t_unfit;
		summarize;
	end
	// Hang guard
	initial begin
		#60000;
		bad_count++;
		summarize;
	end
endmodule : tb_standby_power_sequencer
